//--- ext_ctl.sv
// Model of the reset, boot strap and wake circuitry outside the block.
// Assumes the bench pulses go for one clock with the source code set.
`timescale 1ns/10ps
module ext_ctl #(
   parameter int PW = 4
) (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [2:0] src,
   input  wire logic [1:0] wsel,
   input  wire logic       boot_lvl,
   output logic            por_n,
   output logic            hardware_reset_pin,
   output logic            boot_select_pin,
   output logic [3:0]      external_wake_pins,
   output logic            first_serial_receive_line,
   output logic            primary_timekeeper,
   output logic            secondary_timekeeper,
   output logic            watchdog_timeout
);
   logic [2:0] src_r  = 3'h0;
   logic [1:0] wsel_r = 2'h0;
   int         left   = 0;
   logic [7:0] act;

   always @(posedge clk) begin
      if (go) begin
         left <= PW;
         src_r <= src;
         wsel_r <= wsel;
      end else if (left > 0) begin
         left <= left - 1;
      end
   end

   // One line active for PW cycles; idle levels otherwise
   assign act = (left > 0) ? (8'h01 << src_r) : 8'h00;
   assign hardware_reset_pin = !act[0];
   assign watchdog_timeout = act[1];
   assign por_n = !act[2];
   assign first_serial_receive_line = !act[3];
   assign primary_timekeeper = act[4];
   assign secondary_timekeeper = act[5];
   assign external_wake_pins = act[6] ? (4'h1 << wsel_r) : 4'h0;
   assign boot_select_pin = boot_lvl;
endmodule : ext_ctl

//--- pmode_pkg.sv
// Constants, types and register map for the power mode and boot controller.
// Assumes a 40 MHz system clock and an APB master with 32-bit data.
package pmode_pkg;
   localparam int unsigned CLK_HZ            = 40000000;
   // Wake latencies in nanoseconds
   localparam longint unsigned SHUT_WAKE_NS  = 64'd68144000;
   localparam longint unsigned FAST_WAKE_NS  = 64'd1220000;
   localparam longint unsigned NS_PER_S      = 64'd1000000000;
   localparam int unsigned SHUT_WAKE_CYC =
      int'((SHUT_WAKE_NS * CLK_HZ) / NS_PER_S);
   localparam int unsigned FAST_WAKE_CYC =
      int'((FAST_WAKE_NS * CLK_HZ) / NS_PER_S);
   localparam int unsigned HIB_WAKE_CYC      = 4;
   localparam int unsigned RST_HOLD_CYC      = 8;
   localparam int unsigned CACHE_KB          = 4;
   localparam int unsigned SRAM_RET_KB       = 124;

   localparam logic [11:0] CTRL_ADDR   = 12'h000;
   localparam logic [11:0] STATUS_ADDR = 12'h004;
   localparam logic [11:0] WAKEEN_ADDR = 12'h008;
   localparam logic [11:0] RETAIN_ADDR = 12'h00C;
   localparam logic [11:0] SWRST_ADDR  = 12'h010;
   localparam logic [31:0] SWRST_KEY   = 32'h0000A5A5;

   localparam logic BOOT_SERIAL = 1'b0;
   localparam logic BOOT_FLASH  = 1'b1;

   typedef enum logic [2:0] {
      MODE_ACTIVE    = 3'b000,
      MODE_FLEXI     = 3'b001,
      MODE_HIBERNATE = 3'b010,
      MODE_SHUTDOWN  = 3'b011,
      MODE_FASTSHUT  = 3'b100
   } pmode_t;

   typedef enum logic [1:0] {
      ST_RUN   = 2'b00,
      ST_SLEEP = 2'b01,
      ST_WAKE  = 2'b10,
      ST_RST   = 2'b11
   } pstate_t;

   // Reset cause bits
   typedef struct packed {
      logic por;
      logic pin;
      logic wdt;
      logic sw;
   } rst_cause_t;

   // Power gating controls to the rest of the chip
   typedef struct packed {
      logic core_clk_en;
      logic dma_clk_en;
      logic periph_en;
      logic sram_ret;
      logic isram_ret;
      logic pin_hold;
      logic gpio_cfg_keep;
      logic cache_en;
      logic cache_inval;
   } gate_t;
endpackage : pmode_pkg

//--- power_mode_unit.sv
// Power mode, reset cause and boot mode controller with APB registers.
// Assumes reset pin, boot strap and wake lines are asynchronous to clk.
`timescale 1ns/10ps
// Contract
// - Pin, power-on, watchdog and software reset each restart the system.
// - Boot select low at power-up or hard reset selects serial download.
// - Boot mode 0 is serial download, 1 is flash boot.
// - Serial download mode makes loader configure and use the serial port.
// - Active mode allows all peripherals; power managed by clocks only.
// - Flexi stops core clock; DMA keeps running.
// - Hibernate retains state; SRAM and pin retention configurable.
// - Hibernate wakes on wake pins, serial receive, enabled timekeepers.
// - Shutdown powers everything down; wakes on fewer sources than hibernate.
// - Shutdown may keep primary timekeeper to wake periodically.
// - Shutdown wakes only on pins and primary timekeeper.
// - Pins held in hibernate and shutdown; configuration kept in hibernate only.
// - Enabled cache takes 4 kB of instruction SRAM.
// - Cache invalid after waking from hibernate.
// - Fast-wake shutdown wakes in 1.220 ms versus 68.144 ms.
// - Hibernate retains up to 124 kB SRAM, 124 data or 96+28.
module power_mode_unit #(
   parameter int unsigned SHUT_WAKE = pmode_pkg::SHUT_WAKE_CYC,
   parameter int unsigned FAST_WAKE = pmode_pkg::FAST_WAKE_CYC,
   parameter int unsigned NWAKE     = 4
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               por_n,
   input  wire logic               hardware_reset_pin,
   input  wire logic               boot_select_pin,
   input  wire logic [NWAKE-1:0]   external_wake_pins,
   input  wire logic               first_serial_receive_line,
   input  wire logic               primary_timekeeper,
   input  wire logic               secondary_timekeeper,
   input  wire logic               watchdog_timeout,
   output logic                    sys_rst_n,
   output logic                    boot_mode,
   output logic                    loader_uart_en,
   output pmode_pkg::gate_t        gate
);
   // Two-flop synchronisers for all asynchronous inputs
   localparam int SW = NWAKE + 7;
   // Idle pin levels, so no false edge or reset cause follows rst_n
   localparam logic [SW-1:0] SYNC_IDLE = {{NWAKE{1'b0}}, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
                                          pmode_pkg::BOOT_FLASH, 1'b1};
   logic [SW-1:0] s1_r, s2_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= SYNC_IDLE;
         s2_r <= SYNC_IDLE;
      end else begin
         s1_r <= {external_wake_pins, first_serial_receive_line, primary_timekeeper,
                  secondary_timekeeper, watchdog_timeout, hardware_reset_pin,
                  boot_select_pin, por_n};
         s2_r <= s1_r;
      end
   end
   logic [NWAKE-1:0] wk_pins;
   logic rx_s, tk0_s, tk1_s, wdt_s, hwrst_s, bsel_s, por_s;
   assign {wk_pins, rx_s, tk0_s, tk1_s, wdt_s, hwrst_s, bsel_s, por_s} = s2_r;

   // Registers
   pmode_pkg::pmode_t  mode_r;
   pmode_pkg::pstate_t st_r;
   pmode_pkg::rst_cause_t cause_r;
   logic        sleep_req_r, cache_en_r, tk0_en_r, tk1_en_r;
   logic        sram_ret_r, isram_ret_r, pin_ret_r;
   logic [31:0] cnt_r;
   logic        rx_prev_r, hwrst_prev_r, cache_stale_r, sw_rst_r;
   logic        wr, rd;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;

   // Wake event decoding per mode
   logic rx_fall, wake_ev, rst_ev, hw_pulse;
   assign rx_fall  = rx_prev_r && !rx_s;
   assign hw_pulse = hwrst_prev_r && !hwrst_s;
   always_comb begin
      wake_ev = 1'b0;
      case (mode_r)
         pmode_pkg::MODE_HIBERNATE:
            wake_ev = (|wk_pins) || rx_fall || (tk0_en_r && tk0_s)
                      || (tk1_en_r && tk1_s);
         pmode_pkg::MODE_SHUTDOWN, pmode_pkg::MODE_FASTSHUT:
            wake_ev = (|wk_pins) || (tk0_en_r && tk0_s);
         default: wake_ev = |wk_pins;
      endcase
   end
   assign rst_ev = !por_s || hw_pulse || wdt_s || sw_rst_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_prev_r    <= 1'b1;
         hwrst_prev_r <= 1'b1;
      end else begin
         rx_prev_r    <= rx_s;
         hwrst_prev_r <= hwrst_s;
      end
   end

   // Reset cause capture, set wins over software clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_r <= '{por: 1'b1, default: 1'b0};
      end else begin
         if (wr && paddr == pmode_pkg::STATUS_ADDR)
            cause_r <= cause_r & ~pmode_pkg::rst_cause_t'(pwdata[3:0]);
         if (!por_s)  cause_r.por <= 1'b1;
         if (hw_pulse) cause_r.pin <= 1'b1;
         if (wdt_s)   cause_r.wdt <= 1'b1;
         if (sw_rst_r) cause_r.sw <= 1'b1;
      end
   end

   // Sequencer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r  <= pmode_pkg::ST_RST;
         cnt_r <= '0;
      end else if (rst_ev) begin
         st_r  <= pmode_pkg::ST_RST;
         cnt_r <= '0;
      end else begin
         case (st_r)
            pmode_pkg::ST_RST: begin
               if (cnt_r == 32'(pmode_pkg::RST_HOLD_CYC - 1)) begin
                  st_r  <= pmode_pkg::ST_RUN;
                  cnt_r <= '0;
               end else cnt_r <= cnt_r + 32'd1;
            end
            pmode_pkg::ST_RUN:
               if (sleep_req_r && mode_r != pmode_pkg::MODE_ACTIVE)
                  st_r <= pmode_pkg::ST_SLEEP;
            pmode_pkg::ST_SLEEP: begin
               cnt_r <= '0;
               if (wake_ev) st_r <= pmode_pkg::ST_WAKE;
            end
            pmode_pkg::ST_WAKE: begin
               if (mode_r == pmode_pkg::MODE_FLEXI
                   || mode_r == pmode_pkg::MODE_HIBERNATE) begin
                  if (cnt_r == 32'(pmode_pkg::HIB_WAKE_CYC - 1)) begin
                     st_r <= pmode_pkg::ST_RUN;
                     cnt_r <= '0;
                  end else cnt_r <= cnt_r + 32'd1;
               end else if (cnt_r == 32'((mode_r == pmode_pkg::MODE_FASTSHUT ?
                                         FAST_WAKE : SHUT_WAKE) - 1)) begin
                  st_r  <= pmode_pkg::ST_RST;
                  cnt_r <= '0;
               end else cnt_r <= cnt_r + 32'd1;
            end
            default: st_r <= pmode_pkg::ST_RST;
         endcase
      end
   end

   // Control registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r      <= pmode_pkg::MODE_ACTIVE;
         sleep_req_r <= 1'b0;
         cache_en_r  <= 1'b0;
         tk0_en_r    <= 1'b0;
         tk1_en_r    <= 1'b0;
         sram_ret_r  <= 1'b0;
         isram_ret_r <= 1'b0;
         pin_ret_r   <= 1'b0;
         sw_rst_r    <= 1'b0;
      end else begin
         sw_rst_r <= wr && paddr == pmode_pkg::SWRST_ADDR
                     && pwdata == pmode_pkg::SWRST_KEY;
         if (st_r == pmode_pkg::ST_RST) begin
            mode_r      <= pmode_pkg::MODE_ACTIVE;
            sleep_req_r <= 1'b0;
            cache_en_r  <= 1'b0;
         end else begin
            if (st_r == pmode_pkg::ST_WAKE) sleep_req_r <= 1'b0;
            if (wr && paddr == pmode_pkg::CTRL_ADDR) begin
               if (pwdata[2:0] <= pmode_pkg::MODE_FASTSHUT)
                  mode_r <= pmode_pkg::pmode_t'(pwdata[2:0]);
               sleep_req_r <= pwdata[3];
               cache_en_r  <= pwdata[4];
            end
            if (wr && paddr == pmode_pkg::WAKEEN_ADDR) begin
               tk0_en_r <= pwdata[0];
               tk1_en_r <= pwdata[1];
            end
            if (wr && paddr == pmode_pkg::RETAIN_ADDR) begin
               sram_ret_r  <= pwdata[0];
               isram_ret_r <= pwdata[1];
               pin_ret_r   <= pwdata[2];
            end
         end
      end
   end

   // Cache invalid after a hibernate wake, until the sequencer is back in ST_RUN
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cache_stale_r <= 1'b0;
      else if (st_r == pmode_pkg::ST_WAKE && mode_r == pmode_pkg::MODE_HIBERNATE)
         cache_stale_r <= 1'b1;
      else if (st_r == pmode_pkg::ST_RUN) cache_stale_r <= 1'b0;
   end

   // Boot mode latched at reset release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_mode      <= pmode_pkg::BOOT_FLASH;
         loader_uart_en <= 1'b0;
      end else if (st_r == pmode_pkg::ST_RST
                   && cnt_r == 32'(pmode_pkg::RST_HOLD_CYC - 1)) begin
         boot_mode      <= bsel_s;
         loader_uart_en <= (bsel_s == pmode_pkg::BOOT_SERIAL);
      end
   end

   // Gating outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_rst_n <= 1'b0;
         gate      <= '0;
      end else begin
         sys_rst_n <= (st_r != pmode_pkg::ST_RST) && !rst_ev;
         gate.cache_en    <= cache_en_r && st_r == pmode_pkg::ST_RUN;
         gate.cache_inval <= cache_stale_r;
         if (st_r == pmode_pkg::ST_SLEEP) begin
            gate.core_clk_en <= 1'b0;
            gate.dma_clk_en  <= mode_r == pmode_pkg::MODE_FLEXI;
            gate.periph_en   <= mode_r == pmode_pkg::MODE_FLEXI;
            gate.sram_ret    <= mode_r == pmode_pkg::MODE_HIBERNATE && sram_ret_r;
            gate.isram_ret   <= mode_r == pmode_pkg::MODE_HIBERNATE && isram_ret_r;
            gate.pin_hold    <= (mode_r != pmode_pkg::MODE_FLEXI) && pin_ret_r;
            gate.gpio_cfg_keep <= mode_r != pmode_pkg::MODE_SHUTDOWN
                                  && mode_r != pmode_pkg::MODE_FASTSHUT;
         end else begin
            gate.core_clk_en <= st_r == pmode_pkg::ST_RUN;
            gate.dma_clk_en  <= st_r == pmode_pkg::ST_RUN;
            gate.periph_en   <= st_r == pmode_pkg::ST_RUN;
            gate.sram_ret    <= 1'b0;
            gate.isram_ret   <= 1'b0;
            gate.pin_hold    <= 1'b0;
            gate.gpio_cfg_keep <= 1'b1;
         end
      end
   end

   // APB slave, zero wait state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            if (paddr == pmode_pkg::CTRL_ADDR)
               prdata <= {27'h0, cache_en_r, sleep_req_r, mode_r};
            else if (paddr == pmode_pkg::STATUS_ADDR)
               prdata <= {24'h0, boot_mode, cache_stale_r, st_r, cause_r};
            else if (paddr == pmode_pkg::WAKEEN_ADDR)
               prdata <= {30'h0, tk1_en_r, tk0_en_r};
            else if (paddr == pmode_pkg::RETAIN_ADDR)
               prdata <= {29'h0, pin_ret_r, isram_ret_r, sram_ret_r};
            else begin
               prdata  <= '0;
               pslverr <= paddr != pmode_pkg::SWRST_ADDR;
            end
         end else if (psel && !penable && pwrite) begin
            prdata  <= '0;
            pslverr <= !(paddr == pmode_pkg::CTRL_ADDR || paddr == pmode_pkg::STATUS_ADDR
                         || paddr == pmode_pkg::WAKEEN_ADDR
                         || paddr == pmode_pkg::RETAIN_ADDR
                         || paddr == pmode_pkg::SWRST_ADDR);
         end
      end
   end

   // Assertions
   property p_shut_no_rx;
      @(posedge clk) disable iff (!rst_n)
      (st_r == pmode_pkg::ST_SLEEP && mode_r == pmode_pkg::MODE_SHUTDOWN
       && !(|wk_pins) && !tk0_s && !rst_ev) |=> st_r == pmode_pkg::ST_SLEEP;
   endproperty
   a_shut_no_rx: assert property (p_shut_no_rx) else $error("shutdown woke on bad source");

   property p_hib_rx;
      @(posedge clk) disable iff (!rst_n)
      (st_r == pmode_pkg::ST_SLEEP && mode_r == pmode_pkg::MODE_HIBERNATE
       && rx_fall && !rst_ev) |=> st_r == pmode_pkg::ST_WAKE;
   endproperty
   a_hib_rx: assert property (p_hib_rx) else $error("hibernate missed serial wake");

   property p_flexi_core;
      @(posedge clk) disable iff (!rst_n)
      (st_r == pmode_pkg::ST_SLEEP && mode_r == pmode_pkg::MODE_FLEXI)
      |=> !gate.core_clk_en && gate.dma_clk_en;
   endproperty
   a_flexi_core: assert property (p_flexi_core) else $error("flexi gating wrong");

   property p_rst_out;
      @(posedge clk) disable iff (!rst_n) rst_ev |=> !sys_rst_n;
   endproperty
   a_rst_out: assert property (p_rst_out) else $error("reset cause did not reset");

   property p_boot_hold;
      @(posedge clk) disable iff (!rst_n)
      (st_r == pmode_pkg::ST_RUN && $past(st_r) == pmode_pkg::ST_RUN)
      |-> $stable(boot_mode);
   endproperty
   a_boot_hold: assert property (p_boot_hold) else $error("boot mode changed in run");

   property p_loader;
      @(posedge clk) disable iff (!rst_n)
      loader_uart_en == (boot_mode == pmode_pkg::BOOT_SERIAL);
   endproperty
   a_loader: assert property (p_loader) else $error("loader enable mismatch");

   property p_shut_cfg;
      @(posedge clk) disable iff (!rst_n)
      (st_r == pmode_pkg::ST_SLEEP && mode_r == pmode_pkg::MODE_SHUTDOWN)
      |=> !gate.gpio_cfg_keep && !gate.sram_ret;
   endproperty
   a_shut_cfg: assert property (p_shut_cfg) else $error("shutdown kept config");

   property p_cache_inval;
      @(posedge clk) disable iff (!rst_n)
      (st_r == pmode_pkg::ST_WAKE && mode_r == pmode_pkg::MODE_HIBERNATE)
      |=> ##1 gate.cache_inval;
   endproperty
   a_cache_inval: assert property (p_cache_inval) else $error("cache not invalidated");

   c_hib: cover property (@(posedge clk) st_r == pmode_pkg::ST_SLEEP
                          && mode_r == pmode_pkg::MODE_HIBERNATE ##1 st_r == pmode_pkg::ST_WAKE);
   c_serial: cover property (@(posedge clk) loader_uart_en);
   c_swrst: cover property (@(posedge clk) sw_rst_r);
endmodule : power_mode_unit

//--- tb_top.sv
// Self-checking bench for the power mode and boot controller.
// Assumes the pmode_pkg package and the ext_ctl pin model.
`timescale 1ns/10ps
module tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, go = 1'b0, boot_lvl = 1'b0;
   logic [2:0]  src = 3'h0;
   logic [1:0]  wsel = 2'h0;
   logic        por_n, hw, bsel, rx, tk0, tk1, wdt, sys_rst_n, boot_mode, ldr;
   logic [3:0]  wake;
   pmode_pkg::gate_t gate;
   logic [11:0] outs;
   logic [64:0] rdq[$], re;
   logic [23:0] outq[$], oe;
   logic [31:0] seed = 32'h00015B37;
   logic [3:0]  cbit [4] = '{4'h4, 4'h2, 4'h8, 4'h1};
   int          error_cnt = 0, compares = 0;
   event        seen;

   assign outs = {sys_rst_n, boot_mode, ldr, gate};
   always #12.5 clk = ~clk;

   power_mode_unit #(.SHUT_WAKE(20), .FAST_WAKE(5), .NWAKE(4)) i_power_mode_unit (
      .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .por_n(por_n), .hardware_reset_pin(hw),
      .boot_select_pin(bsel), .external_wake_pins(wake),
      .first_serial_receive_line(rx), .primary_timekeeper(tk0),
      .secondary_timekeeper(tk1), .watchdog_timeout(wdt), .sys_rst_n(sys_rst_n),
      .boot_mode(boot_mode), .loader_uart_en(ldr), .gate(gate));

   ext_ctl #(.PW(4)) i_ext_ctl (
      .clk(clk), .go(go), .src(src), .wsel(wsel), .boot_lvl(boot_lvl), .por_n(por_n),
      .hardware_reset_pin(hw), .boot_select_pin(bsel), .external_wake_pins(wake),
      .first_serial_receive_line(rx), .primary_timekeeper(tk0),
      .secondary_timekeeper(tk1), .watchdog_timeout(wdt));

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic bad(input string what);
      error_cnt++;
      $display("Error %0t: %s mismatch", $time, what);
   endtask : bad

   task automatic cmp_rd(input logic [31:0] got, input logic err, input logic [64:0] e);
      compares++;
      if (((got & e[63:32]) !== e[31:0]) || (err !== e[64])) bad("read");
   endtask : cmp_rd

   task automatic cmp_out(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp) bad("output");
   endtask : cmp_out

   task automatic cmp_lat(input int got, input int lo, input int hi);
      compares++;
      if (got < lo || got > hi) bad("wake latency");
   endtask : cmp_lat

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
      if (!w) rdq.push_back({e, m, d});
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic ev(input logic [2:0] s);
      @(posedge clk);
      go <= 1'b1;
      src <= s;
      wsel <= 2'(xs());
      @(posedge clk);
      go <= 1'b0;
   endtask : ev

   // Waits up to n cycles for the masked outputs, then notes the result
   task automatic obs(input logic [11:0] m, input logic [11:0] e, input int n);
      int k;
      k = 0;
      @(negedge clk);
      while ((outs & m) !== e && k < n) begin
         @(negedge clk);
         k++;
      end
      outq.push_back({m, e});
      -> seen;
      #1;
   endtask : obs

   task automatic wake_lat(input int w);
      int k;
      k = 0;
      while (!(sys_rst_n === 1'b1 && gate.core_clk_en === 1'b1) && k < 400) begin
         @(negedge clk);
         k++;
      end
      cmp_lat(k, w + 8, w + 20);
   endtask : wake_lat

   task end_sim;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim

   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         re = rdq.pop_front();
         cmp_rd(prdata, pslverr, re);
      end
   end

   always @(seen) begin
      oe = outq.pop_front();
      cmp_out(outs & oe[23:12], oe[11:0]);
   end

   initial begin
      #(25 * 8000);
      error_cnt++;
      end_sim;
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      obs(12'hE00, 12'hA00, 40);
      @(posedge clk);
      boot_lvl <= 1'b1;
      repeat (5) @(posedge clk);
      obs(12'hE00, 12'hA00, 0);
      obs(12'h940, 12'h940, 0);
      apb(0, 12'h020, 32'h0, 32'hFFFFFFFF, 1'b1);
      apb(1, pmode_pkg::CTRL_ADDR, 32'h10, 0, 0);
      obs(12'h002, 12'h002, 10);
      apb(1, pmode_pkg::CTRL_ADDR, 32'h19, 0, 0);
      obs(12'h980, 12'h880, 10);
      ev(3'd6);
      obs(12'h900, 12'h900, 20);
      apb(1, pmode_pkg::RETAIN_ADDR, 32'h7, 0, 0);
      apb(1, pmode_pkg::CTRL_ADDR, 32'h1A, 0, 0);
      obs(12'h93C, 12'h83C, 10);
      ev(3'd5);
      repeat (20) @(posedge clk);
      obs(12'h900, 12'h800, 0);
      ev(3'd3);
      obs(12'h001, 12'h001, 20);
      obs(12'h900, 12'h900, 20);
      apb(1, pmode_pkg::WAKEEN_ADDR, 32'h3, 0, 0);
      apb(1, pmode_pkg::CTRL_ADDR, 32'h0B, 0, 0);
      obs(12'h10C, 12'h008, 10);
      ev(3'd5);
      repeat (30) @(posedge clk);
      obs(12'h100, 12'h000, 0);
      ev(3'd3);
      repeat (30) @(posedge clk);
      obs(12'h100, 12'h000, 0);
      ev(3'd4);
      wake_lat(20);
      apb(0, pmode_pkg::CTRL_ADDR, 32'h0, 32'h1F, 0);
      apb(1, pmode_pkg::CTRL_ADDR, 32'h0C, 0, 0);
      obs(12'h100, 12'h000, 10);
      ev(3'd6);
      wake_lat(5);
      for (int i = 0; i < 4; i++) begin
         apb(1, pmode_pkg::STATUS_ADDR, 32'hF, 0, 0);
         if (i == 3) begin
            apb(1, pmode_pkg::SWRST_ADDR, pmode_pkg::SWRST_KEY, 0, 0);
         end else begin
            ev(i[2:0]);
         end
         obs(12'h800, 12'h000, 40);
         obs(12'h800, 12'h800, 60);
         apb(0, pmode_pkg::STATUS_ADDR, {28'h0, cbit[i]}, 32'hF, 0);
      end
      obs(12'hE00, 12'hC00, 0);
      end_sim;
   end
endmodule : tb_top
